// ---- rtl/diag_flags_pkg.sv ----
package diag_flags_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] STATUS_CONTROL_OFS = 8'h6e;
  localparam logic [7:0] ALARM_FIRST_OFS    = 8'h70;
  localparam logic [7:0] ALARM_SECOND_OFS   = 8'h71;
  localparam logic [7:0] WARN_FIRST_OFS     = 8'h74;
  localparam logic [7:0] WARN_SECOND_OFS    = 8'h75;
  localparam logic [7:0] UNMAPPED_RDATA     = 8'h00;
  // ==========================================================
  // status/control field positions
  localparam int TXDIS_PIN_BIT  = 7;
  localparam int SOFT_TXDIS_BIT = 6;
  localparam int TX_FAULT_BIT   = 2;
  localparam int RX_LOST_BIT    = 1;
  localparam int NOT_READY_BIT  = 0;
  localparam logic SOFT_TXDIS_RST = 1'b0;
  // ==========================================================
  // monitored quantities and threshold kinds
  localparam int NQ        = 5;
  localparam int Q_TEMP    = 0;
  localparam int Q_VCC     = 1;
  localparam int Q_BIAS    = 2;
  localparam int Q_TXPWR   = 3;
  localparam int Q_RXPWR   = 4;
  localparam int MEAS_W    = 16;
  localparam int NTHR      = 4;
  localparam int T_HI_ALM  = 0;
  localparam int T_LO_ALM  = 1;
  localparam int T_HI_WRN  = 2;
  localparam int T_LO_WRN  = 3;
  localparam logic [MEAS_W-1:0] THR_HI_RST = 16'hffff;
  localparam logic [MEAS_W-1:0] THR_LO_RST = 16'h0000;
  localparam logic [MEAS_W-1:0] MEAS_RST   = 16'h0000;
  localparam logic [NQ-1:0]     SIGNED_Q   = 5'h01;
  // ==========================================================
  // timing
  localparam longint CLK_PERIOD_NS   = 4;
  localparam longint SOFT_RESPONSE_MS = 100;
  localparam longint SOFT_RESPONSE_CYC =
    (SOFT_RESPONSE_MS * 1000000) / CLK_PERIOD_NS;
endpackage

// ---- rtl/diag_status_alarm_flags.sv ----
`timescale 1ns/1ns
module diag_status_alarm_flags #(
  parameter int RESPONSE_CYCLES =
    int'(diag_flags_pkg::SOFT_RESPONSE_CYC) // soft command deadline
) (
  input  wire logic        i_core_clk,       // core clock, 250 mhz
  input  wire logic        i_srst,           // sync reset, active high
  input  wire logic [7:0]  i_reg_addr,       // byte offset from engine
  input  wire logic        i_reg_wr,         // byte write strobe
  input  wire logic [7:0]  i_reg_wdata,      // byte write data
  input  wire logic        i_reg_rd,         // byte read strobe
  input  wire logic        i_txdis_pin,      // transmit-disable pin
  input  wire logic        i_tx_fault_pin,   // transmit-fault pin level
  input  wire logic        i_receive_signal_lost_pin, // loss of signal
  input  wire logic        i_power_good,     // supplies are up
  input  wire logic        i_meas_wr,        // measurement store strobe
  input  wire logic [2:0]  i_meas_sel,       // quantity index
  input  wire logic [15:0] i_meas_value,     // new measurement
  input  wire logic        i_thr_wr,         // threshold store strobe
  input  wire logic [2:0]  i_thr_sel,        // quantity index
  input  wire logic [1:0]  i_thr_kind,       // threshold kind
  input  wire logic [15:0] i_thr_value,      // new threshold
  output logic [7:0]       o_reg_rdata,      // read data, next cycle
  output logic             o_tx_disabled     // transmitter disabled
);
  import diag_flags_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]                       rdata;     // read data
    logic                             soft_dis;  // host soft disable
    logic                             txdis;     // disable output
    logic                             pin_s;     // sampled disable pin
    logic                             fault_s;   // sampled fault pin
    logic                             lost_s;    // sampled loss pin
    logic                             not_ready; // data-ready bar
    logic [NQ-1:0]                    stored;    // quantities seen
    logic [NQ-1:0][MEAS_W-1:0]        meas;      // measurements
    logic [NQ-1:0][NTHR-1:0][MEAS_W-1:0] thr;    // thresholds
    logic [NQ-1:0]                    alm_hi;    // high alarms
    logic [NQ-1:0]                    alm_lo;    // low alarms
    logic [NQ-1:0]                    wrn_hi;    // high warnings
    logic [NQ-1:0]                    wrn_lo;    // low warnings
  } state_t;

  state_t state_r;   // registered state
  state_t state_nxt; // next state

  // per-quantity compare results against the incoming value
  logic [NQ-1:0] cmp_ahi;
  logic [NQ-1:0] cmp_alo;
  logic [NQ-1:0] cmp_whi;
  logic [NQ-1:0] cmp_wlo;

  // ==========================================================
  // threshold compares, signed for temperature only
  genvar g;
  generate
    for (g = 0; g < NQ; g++) begin : g_cmp
      if (SIGNED_Q[g]) begin : g_s
        always_comb begin
          cmp_ahi[g] = $signed(i_meas_value) >
                       $signed(state_r.thr[g][T_HI_ALM]);
          cmp_alo[g] = $signed(i_meas_value) <
                       $signed(state_r.thr[g][T_LO_ALM]);
          cmp_whi[g] = $signed(i_meas_value) >
                       $signed(state_r.thr[g][T_HI_WRN]);
          cmp_wlo[g] = $signed(i_meas_value) <
                       $signed(state_r.thr[g][T_LO_WRN]);
        end
      end else begin : g_u
        always_comb begin
          cmp_ahi[g] = i_meas_value > state_r.thr[g][T_HI_ALM];
          cmp_alo[g] = i_meas_value < state_r.thr[g][T_LO_ALM];
          cmp_whi[g] = i_meas_value > state_r.thr[g][T_HI_WRN];
          cmp_wlo[g] = i_meas_value < state_r.thr[g][T_LO_WRN];
        end
      end
    end
  endgenerate

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [7:0] status_byte;
    status_byte = 8'h00;
    state_nxt   = state_r;
    // pin sampling
    state_nxt.pin_s   = i_txdis_pin;
    state_nxt.fault_s = i_tx_fault_pin;
    state_nxt.lost_s  = i_receive_signal_lost_pin;
    // soft disable write, other bits of the byte ignored
    if (i_reg_wr && i_reg_addr == STATUS_CONTROL_OFS) begin
      state_nxt.soft_dis = i_reg_wdata[SOFT_TXDIS_BIT];
    end
    // transmitter off if either source asserts
    state_nxt.txdis = i_txdis_pin | state_nxt.soft_dis;
    // measurement store re-evaluates that quantity's flags
    if (i_meas_wr && i_meas_sel < 3'(NQ)) begin
      state_nxt.meas[i_meas_sel]   = i_meas_value;
      state_nxt.stored[i_meas_sel] = 1'b1;
      state_nxt.alm_hi[i_meas_sel] = cmp_ahi[i_meas_sel];
      state_nxt.alm_lo[i_meas_sel] = cmp_alo[i_meas_sel];
      state_nxt.wrn_hi[i_meas_sel] = cmp_whi[i_meas_sel];
      state_nxt.wrn_lo[i_meas_sel] = cmp_wlo[i_meas_sel];
    end
    // threshold store, takes effect at next measurement
    if (i_thr_wr && i_thr_sel < 3'(NQ)) begin
      state_nxt.thr[i_thr_sel][i_thr_kind] = i_thr_value;
    end
    // ready once powered and every quantity has been measured
    state_nxt.not_ready = !(i_power_good &&
                            (&state_r.stored));
    // status byte image
    status_byte[TXDIS_PIN_BIT]  = state_r.pin_s;
    status_byte[SOFT_TXDIS_BIT] = state_r.soft_dis;
    status_byte[TX_FAULT_BIT]   = state_r.fault_s;
    status_byte[RX_LOST_BIT]    = state_r.lost_s;
    status_byte[NOT_READY_BIT]  = state_r.not_ready;
    // read mux, answered in the following cycle
    if (i_reg_rd) begin
      case (i_reg_addr)
        STATUS_CONTROL_OFS: state_nxt.rdata = status_byte;
        ALARM_FIRST_OFS: begin
          state_nxt.rdata = {state_r.alm_hi[Q_TEMP],
                             state_r.alm_lo[Q_TEMP],
                             state_r.alm_hi[Q_VCC],
                             state_r.alm_lo[Q_VCC],
                             state_r.alm_hi[Q_BIAS],
                             state_r.alm_lo[Q_BIAS],
                             state_r.alm_hi[Q_TXPWR],
                             state_r.alm_lo[Q_TXPWR]};
        end
        ALARM_SECOND_OFS: begin
          state_nxt.rdata = {state_r.alm_hi[Q_RXPWR],
                             state_r.alm_lo[Q_RXPWR], 6'h00};
        end
        WARN_FIRST_OFS: begin
          state_nxt.rdata = {state_r.wrn_hi[Q_TEMP],
                             state_r.wrn_lo[Q_TEMP],
                             state_r.wrn_hi[Q_VCC],
                             state_r.wrn_lo[Q_VCC],
                             state_r.wrn_hi[Q_BIAS],
                             state_r.wrn_lo[Q_BIAS],
                             state_r.wrn_hi[Q_TXPWR],
                             state_r.wrn_lo[Q_TXPWR]};
        end
        WARN_SECOND_OFS: begin
          state_nxt.rdata = {state_r.wrn_hi[Q_RXPWR],
                             state_r.wrn_lo[Q_RXPWR], 6'h00};
        end
        default: state_nxt.rdata = UNMAPPED_RDATA;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_r           <= '0;
      state_r.soft_dis  <= SOFT_TXDIS_RST;
      state_r.not_ready <= 1'b1;
      for (int q = 0; q < NQ; q++) begin
        state_r.meas[q]           <= MEAS_RST;
        state_r.thr[q][T_HI_ALM]  <= THR_HI_RST;
        state_r.thr[q][T_LO_ALM]  <= THR_LO_RST;
        state_r.thr[q][T_HI_WRN]  <= THR_HI_RST;
        state_r.thr[q][T_LO_WRN]  <= THR_LO_RST;
      end
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from flops
  assign o_reg_rdata   = state_r.rdata;
  assign o_tx_disabled = state_r.txdis;

  // ==========================================================
  // checks
  // consecutive cycles the output disagrees with soft bit or disable pin
  logic [31:0] rsp_cnt_r;
  always_ff @(posedge i_core_clk) begin
    if (i_srst || o_tx_disabled == (state_r.soft_dis | i_txdis_pin))
      rsp_cnt_r <= 32'h0;
    else
      rsp_cnt_r <= rsp_cnt_r + 32'h1;
  end

  // all checks below share the core clock and the sync reset
  default clocking chk_cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  sequence soft_set_s;
    i_reg_wr && i_reg_addr == STATUS_CONTROL_OFS &&
    i_reg_wdata[SOFT_TXDIS_BIT];
  endsequence

  sequence read_status_s;
    i_reg_rd && i_reg_addr == STATUS_CONTROL_OFS;
  endsequence

  pin_mirror_a: assert property (
    ##1 read_status_s ##0 $past(i_txdis_pin) |=>
      o_reg_rdata[TXDIS_PIN_BIT] == $past(i_txdis_pin, 2))
    else $error("disable pin state misread");
  soft_rw_a: assert property (
    soft_set_s ##1 !i_reg_wr ##1 (read_status_s and !i_reg_wr) |=>
      o_reg_rdata[SOFT_TXDIS_BIT])
    else $error("soft disable did not read back");
  soft_or_a: assert property (
    soft_set_s |=> o_tx_disabled)
    else $error("soft disable did not disable transmitter");
  fault_mirror_a: assert property (
    ##2 read_status_s |=>
      o_reg_rdata[TX_FAULT_BIT] == $past(i_tx_fault_pin, 2))
    else $error("fault pin state misread");
  lost_mirror_a: assert property (
    ##2 read_status_s |=>
      o_reg_rdata[RX_LOST_BIT] == $past(i_receive_signal_lost_pin, 2))
    else $error("loss pin state misread");
  not_ready_a: assert property (
    !i_power_good |=> state_r.not_ready)
    else $error("ready shown while unpowered");
  soft_time_a: assert property (
    rsp_cnt_r < 32'(RESPONSE_CYCLES))
    else $error("soft command response too slow");
  rsvd_zero_a: assert property (
    i_reg_rd && (i_reg_addr == ALARM_SECOND_OFS ||
                 i_reg_addr == WARN_SECOND_OFS) |=>
      o_reg_rdata[5:0] == 6'h00)
    else $error("reserved flag bits not zero");
  temp_sign_a: assert property (
    i_meas_wr && i_meas_sel == 3'(Q_TEMP) && i_meas_value[15] &&
    !state_r.thr[Q_TEMP][T_HI_ALM][15] |=> !state_r.alm_hi[Q_TEMP])
    else $error("negative temperature raised high alarm");
  vcc_high_a: assert property (
    i_meas_wr && i_meas_sel == 3'(Q_VCC) &&
    i_meas_value > state_r.thr[Q_VCC][T_HI_ALM] |=>
      state_r.alm_hi[Q_VCC])
    else $error("supply high alarm missed");
  flag_clear_a: assert property (
    i_meas_wr && i_meas_sel == 3'(Q_RXPWR) &&
    i_meas_value >= state_r.thr[Q_RXPWR][T_LO_WRN] |=>
      !state_r.wrn_lo[Q_RXPWR])
    else $error("low warning not cleared");
endmodule

// ---- tb/host_ctrl_model.sv ----
`timescale 1ns/1ns
// ==========================================================
// host management controller: byte reads and writes
module host_ctrl_model (
  input  wire logic       i_clk,   // core clock
  input  wire logic [7:0] i_rdata, // read data from the block
  output logic [7:0]      o_addr,  // byte offset
  output logic            o_wr,    // write strobe
  output logic [7:0]      o_wdata, // write data
  output logic            o_rd     // read strobe
);
  // idle bus at time zero
  initial begin
    o_addr  = 8'h00;
    o_wr    = 1'b0;
    o_wdata = 8'h00;
    o_rd    = 1'b0;
  end
  // one write pulse; released lines are driven to their complements, not held
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
  // one read pulse; data taken an edge after the read edge
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd   = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd   = 1'b0;
    o_addr = ~a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask
endmodule

// ---- tb/tb_diag_status_alarm_flags.sv ----
`timescale 1ns/1ns
// ==========================================================
// bench for the status/control and flag bytes
module tb_diag_status_alarm_flags;
  import diag_flags_pkg::*;
  localparam int RESP = 16; // shortened soft-command deadline
  localparam logic [15:0] THR [4] = '{16'h4000, 16'h1000, 16'h3000, 16'h2000};
  localparam logic [15:0] VAL [5] = '{16'h5000, 16'h3800, 16'h0800,
                                      16'h1800, 16'h2800};
  localparam logic [3:0]  EXP [5] = '{4'b1010, 4'b0010, 4'b0101,
                                      4'b0001, 4'b0000};
  logic        clk, srst, wr, rd, txdis, fault, los, pgood, mwr, twr, txoff;
  logic [7:0]  addr, wdata, rdata;
  logic [2:0]  msel, tsel;
  logic [1:0]  tkind;
  logic [15:0] mval, tval;
  logic [4:0]  ha, la, hw, lw; // expected flags per quantity
  int          fails, n_compared;
  diag_status_alarm_flags #(
    .RESPONSE_CYCLES(RESP)
  ) diag_status_alarm_flags_inst (
    .i_core_clk(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .i_txdis_pin(txdis),
    .i_tx_fault_pin(fault), .i_receive_signal_lost_pin(los),
    .i_power_good(pgood), .i_meas_wr(mwr), .i_meas_sel(msel),
    .i_meas_value(mval), .i_thr_wr(twr), .i_thr_sel(tsel),
    .i_thr_kind(tkind), .i_thr_value(tval), .o_reg_rdata(rdata),
    .o_tx_disabled(txoff));
  host_ctrl_model host_ctrl_model_inst (.i_clk(clk), .i_rdata(rdata),
    .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // comparisons and verdict
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // stimulus helpers
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_ctrl_model_inst.read_byte(a, d);
    cmp_byte(d, e);
  endtask
  task automatic thr_set(input int q, input int k, input logic [15:0] v);
    @(posedge clk);
    #1;
    {twr, tsel, tkind, tval} = {1'b1, 3'(q), 2'(k), v};
    @(posedge clk);
    #1;
    twr = 1'b0;
  endtask
  task automatic meas_set(input int q, input logic [15:0] v);
    @(posedge clk);
    #1;
    {mwr, msel, mval} = {1'b1, 3'(q), v};
    @(posedge clk);
    #1;
    mwr = 1'b0;
  endtask
  // expected flag byte: first packs four pairs, second the rx pair
  function automatic logic [7:0] fbyte(input logic [4:0] h, l, input bit s);
    if (s) return {h[4], l[4], 6'h00};
    return {h[0], l[0], h[1], l[1], h[2], l[2], h[3], l[3]};
  endfunction
  task automatic chk_flags();
    rd_chk(ALARM_FIRST_OFS, fbyte(ha, la, 1'b0));
    rd_chk(ALARM_SECOND_OFS, fbyte(ha, la, 1'b1));
    rd_chk(WARN_FIRST_OFS, fbyte(hw, lw, 1'b0));
    rd_chk(WARN_SECOND_OFS, fbyte(hw, lw, 1'b1));
  endtask
  // bounded wait for the transmitter state to follow a command
  task automatic wait_off(input logic e);
    for (int i = 0; i < RESP && txoff !== e; i++) begin
      @(posedge clk);
      #1;
    end
    cmp_bit(txoff, e);
    if (txoff !== e) close_out();
  endtask
  // ==========================================================
  // scenarios
  task automatic test_reset();
    rd_chk(STATUS_CONTROL_OFS, 8'h01);
    rd_chk(8'h6f, UNMAPPED_RDATA);
    cmp_bit(txoff, 1'b0);
    $display("test reset done");
  endtask
  task automatic test_soft();
    host_ctrl_model_inst.write_byte(STATUS_CONTROL_OFS, 8'hff);
    wait_off(1'b1);
    rd_chk(STATUS_CONTROL_OFS, 8'h41);
    host_ctrl_model_inst.write_byte(ALARM_FIRST_OFS, 8'hff);
    rd_chk(ALARM_FIRST_OFS, 8'h00);
    host_ctrl_model_inst.write_byte(STATUS_CONTROL_OFS, 8'h00);
    wait_off(1'b0);
    $display("test soft done");
  endtask
  task automatic test_pins();
    {txdis, fault, los} = 3'b110;
    wait_off(1'b1);
    rd_chk(STATUS_CONTROL_OFS, 8'h85);
    {txdis, fault, los} = 3'b001;
    wait_off(1'b0);
    rd_chk(STATUS_CONTROL_OFS, 8'h03);
    los = 1'b0;
    $display("test pins done");
  endtask
  task automatic test_flags();
    pgood = 1'b1;
    for (int q = 0; q < NQ; q++)
      for (int k = 0; k < NTHR; k++) thr_set(q, k, THR[k]);
    for (int q = 0; q < NQ; q++) begin
      meas_set(q, 16'h2800);
      rd_chk(STATUS_CONTROL_OFS, {7'h00, q < NQ - 1});
    end
    chk_flags();
    for (int q = 0; q < NQ; q++)
      for (int v = 0; v < 5; v++) begin
        meas_set(q, VAL[v]);
        {ha[q], la[q], hw[q], lw[q]} = EXP[v];
        chk_flags();
      end
    meas_set(Q_TEMP, 16'hff00);
    {la[0], lw[0]} = 2'b11;
    chk_flags();
    meas_set(Q_VCC, 16'hff00);
    {ha[1], hw[1]} = 2'b11;
    meas_set(5, 16'h5000);
    chk_flags();
    pgood = 1'b0;
    rd_chk(STATUS_CONTROL_OFS, 8'h01);
    $display("test flags done");
  endtask
  // reset in mid-run clears soft bit, flags and ready state
  task automatic test_reset_mid();
    host_ctrl_model_inst.write_byte(STATUS_CONTROL_OFS, 8'h40);
    wait_off(1'b1);
    srst = 1'b1;
    @(posedge clk);
    #1;
    srst = 1'b0;
    cmp_bit(txoff, 1'b0);
    {ha, la, hw, lw} = '0;
    chk_flags();
    rd_chk(STATUS_CONTROL_OFS, 8'h01);
    $display("test mid reset done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {srst, txdis, fault, los, pgood, mwr, twr} = 7'h40;
    {msel, tsel, tkind, mval, tval} = '0;
    {ha, la, hw, lw} = '0;
    fails = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    test_reset();
    test_soft();
    test_pins();
    test_flags();
    test_reset_mid();
    close_out();
  end
endmodule
